// file: fcsc_host.sv
/* host model for the config pins: request, clock, data, pull-ups.
   assumes device enables are high while it pulls a line low. */
`timescale 1ns/1ps
module fcsc_host (
  input  wire logic        config_status_n_oe,
  input  wire logic        load_complete_line_oe,
  output logic             config_request_n,
  output logic             config_clock_in,
  output logic [15:0]      config_data,
  output wire logic        config_status_n_in,
  output wire logic        load_complete_line_in
);
  assign config_status_n_in = !config_status_n_oe;
  assign load_complete_line_in = !load_complete_line_oe;
  // data settles before the rise, clock parks low after
  task automatic send(input logic [15:0] w);
    config_data = w;
    #24 config_clock_in = 1'b1;
    #24 config_clock_in = 1'b0;
    config_data = ~w;
  endtask : send
  // request held low for c system cycles
  task automatic pulse(input int c);
    config_request_n = 1'b0;
    #(c * 4) config_request_n = 1'b1;
  endtask : pulse
  initial begin
    config_request_n = 1'b0;
    config_clock_in = 1'b0;
    config_data = 16'h0000;
    #40 config_request_n = 1'b1;
  end
endmodule : fcsc_host

// file: fcsc_loader.sv
/*
  Configuration sequence controller: power-on reset, reset hold, stream
  loading in three schemes, error and auto restart, initialization clocking
  and user mode, with an AXI4-Lite register slave.
  Assumes open-drain lines are resolved outside from the enables, and that
  every pin input is asynchronous to clk.
*/
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "fcsc_params.svh"

module fcsc_loader
  import fcsc_pkg::*;
#(
  parameter logic [31:0] POR_SHORT_CYC = 32'(`FCSC_CYC_UP(`FCSC_POR_SHORT_NS)),
  parameter logic [31:0] POR_LONG_CYC  = 32'(`FCSC_CYC_UP(`FCSC_POR_LONG_NS)),
  parameter logic [31:0] INIT_CYCLES   = 32'(`FCSC_INIT_CYCLES)
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // configuration pins
  input  wire logic        config_request_n,
  input  wire logic        config_status_n_in,
  output logic             config_status_n_out,
  output logic             config_status_n_oe,
  input  wire logic        load_complete_line_in,
  output logic             load_complete_line_out,
  output logic             load_complete_line_oe,
  input  wire logic        config_clock_in,
  output logic             config_clock_out,
  output logic             config_clock_oe,
  input  wire logic [15:0] config_data,
  input  wire logic [3:0]  serial_config_data,
  input  wire logic        user_init_clock,
  input  wire logic [2:0]  mode_select_pins,
  // towards the fabric
  output fcsc_cram_t       cram,
  output logic             user_io_tristate,
  output logic             user_pullup_en,
  output logic             init_done
);

  localparam logic [31:0] STATUS_REL_CYC = 32'(`FCSC_CYC_UP(`FCSC_STATUS_REL_NS));
  localparam logic [31:0] CFG_PULSE_CYC  = 32'(`FCSC_CYC_UP(`FCSC_CFG_PULSE_NS));
  localparam logic [31:0] CD2CU_CYC      = 32'(`FCSC_CYC_UP(`FCSC_CD2CU_NS));
  localparam logic [7:0]  OSC_HALF       = 8'(`FCSC_OSC_HALF_CYC);
  localparam logic [7:0]  AS_HALF        = 8'(`FCSC_AS_HALF_CYC);

  // ***********************************************************************
  // state
  // ***********************************************************************
  typedef struct packed {
    fcsc_phase_t phase;
    logic [1:0]  por_arm;
    logic [31:0] cnt;
    logic [31:0] req_low;
    logic [1:0]  req_s, stat_s, config_clock_s, usr_s;
    logic        config_clock_d, usr_d;
    logic [2:0]  mode_select_pins_s0, mode_select_pins_s1;
    logic [15:0] dat_s0, dat_s1;
    logic [3:0]  as_s0, as_s1;
    logic [7:0]  osc_div;
    logic        osc;
    logic [7:0]  as_div;
    logic        as_clk;
    logic [15:0] shift;
    logic [4:0]  bitcnt;
    logic [15:0] words, xsum;
    logic [1:0]  falls;
    fcsc_cram_t  cram;
    logic        init_done;
    logic [5:0]  ctrl;
    logic [15:0] len, chk;
    logic        aw_full, w_full;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
  } fcsc_state_t;

  fcsc_state_t st_reg;
  fcsc_state_t st_next;

  fcsc_scheme_t scheme;
  logic         passive;
  logic         config_clock_rise, config_clock_fall, usr_rise, osc_rise, as_rise, init_edge;
  logic         req_pulse, word_done;
  logic [15:0]  word_val;

  // byte-enable merge of a write into a stored register
  function automatic logic [31:0] fcsc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : fcsc_merge

  // ***********************************************************************
  // next-state logic
  // ***********************************************************************
  always_comb begin
    logic [31:0] merged;
    logic [31:0] rd;
    merged  = 32'h00000000;
    rd      = 32'h00000000;
    st_next = st_reg;

    // pin synchronisers: first stage only feeds the second
    st_next.req_s   = {st_reg.req_s[0], config_request_n};
    st_next.stat_s  = {st_reg.stat_s[0], config_status_n_in};
    st_next.config_clock_s  = {st_reg.config_clock_s[0], config_clock_in};
    st_next.usr_s   = {st_reg.usr_s[0], user_init_clock};
    st_next.mode_select_pins_s0 = mode_select_pins;
    st_next.mode_select_pins_s1 = st_reg.mode_select_pins_s0;
    st_next.dat_s0  = config_data;
    st_next.dat_s1  = st_reg.dat_s0;
    st_next.as_s0   = serial_config_data;
    st_next.as_s1   = st_reg.as_s0;
    st_next.config_clock_d  = st_reg.config_clock_s[1];
    st_next.usr_d   = st_reg.usr_s[1];
    st_next.cram.we = 1'b0;

    scheme    = fcsc_scheme_t'(st_reg.ctrl[`FCSC_CTRL_SCHEME]);
    passive   = (scheme != SCH_ACTIVE_SERIAL);
    config_clock_rise = st_reg.config_clock_s[1] & ~st_reg.config_clock_d;
    config_clock_fall = ~st_reg.config_clock_s[1] & st_reg.config_clock_d;
    usr_rise  = st_reg.usr_s[1] & ~st_reg.usr_d;

    // internal oscillator derived from the system clock
    osc_rise = 1'b0;
    if (st_reg.osc_div == OSC_HALF - 8'h01) begin
      st_next.osc_div = 8'h00;
      st_next.osc     = ~st_reg.osc;
      osc_rise        = ~st_reg.osc;
    end else begin
      st_next.osc_div = st_reg.osc_div + 8'h01;
    end

    // active scheme drives its own config clock while loading
    as_rise = 1'b0;
    if (st_reg.phase == PH_CONFIG && scheme == SCH_ACTIVE_SERIAL) begin
      if (st_reg.as_div == AS_HALF - 8'h01) begin
        st_next.as_div = 8'h00;
        st_next.as_clk = ~st_reg.as_clk;
        as_rise        = ~st_reg.as_clk;
      end else begin
        st_next.as_div = st_reg.as_div + 8'h01;
      end
    end else begin
      st_next.as_div = 8'h00;
      st_next.as_clk = 1'b0;
    end

    // only the selected init clock is counted
    unique case (st_reg.ctrl[`FCSC_CTRL_CLKSEL])
      2'b01:   init_edge = usr_rise;
      2'b10:   init_edge = config_clock_rise;
      default: init_edge = osc_rise;
    endcase

    // request low width measured against the minimum pulse
    if (!st_reg.req_s[1]) begin
      if (st_reg.req_low != CFG_PULSE_CYC) begin
        st_next.req_low = st_reg.req_low + 32'h00000001;
      end
    end else begin
      st_next.req_low = 32'h00000000;
    end
    req_pulse = (st_reg.req_low == CFG_PULSE_CYC);

    // word assembly per scheme; a paused clock just waits
    word_done = 1'b0;
    word_val  = 16'h0000;
    if (st_reg.phase == PH_CONFIG) begin
      unique case (scheme)
        SCH_SERIAL_PASSIVE: if (config_clock_rise) begin
          st_next.shift  = {st_reg.shift[14:0], st_reg.dat_s1[0]};
          st_next.bitcnt = st_reg.bitcnt + 5'h01;
          word_done      = (st_reg.bitcnt == 5'h0F);
          word_val       = {st_reg.shift[14:0], st_reg.dat_s1[0]};
        end
        SCH_ACTIVE_SERIAL: if (as_rise) begin
          st_next.shift  = {st_reg.shift[11:0], st_reg.as_s1};
          st_next.bitcnt = st_reg.bitcnt + 5'h04;
          word_done      = (st_reg.bitcnt == 5'h0C);
          word_val       = {st_reg.shift[11:0], st_reg.as_s1};
        end
        default: if (config_clock_rise) begin
          word_done = 1'b1;
          word_val  = st_reg.dat_s1;
        end
      endcase
      if (word_done) begin
        st_next.bitcnt    = 5'h00;
        st_next.cram.word = word_val;
        st_next.cram.we   = 1'b1;
        st_next.words     = st_reg.words + 16'h0001;
        st_next.xsum      = st_reg.xsum ^ word_val;
      end
    end

    unique case (st_reg.phase)
      PH_POR: begin
        // delay length caught from the settled mode-select level
        if (st_reg.por_arm != 2'h3) begin
          st_next.por_arm = st_reg.por_arm + 2'h1;
          st_next.cnt     = st_reg.mode_select_pins_s1[0] ? POR_LONG_CYC : POR_SHORT_CYC;
        end else if (st_reg.cnt == 32'h00000000) begin
          st_next.phase = PH_RESET;
        end else begin
          st_next.cnt = st_reg.cnt - 32'h00000001;
        end
      end
      PH_RESET: begin
        // load only once request and status both read high
        if (st_reg.req_s[1] && st_reg.stat_s[1]) begin
          st_next.phase  = PH_CONFIG;
          st_next.words  = 16'h0000;
          st_next.xsum   = 16'h0000;
          st_next.bitcnt = 5'h00;
          st_next.shift  = 16'h0000;
        end
      end
      PH_CONFIG: begin
        // last word closes the stream, checked against the sum
        if (word_done && (st_reg.words + 16'h0001 == st_reg.len)) begin
          st_next.cnt   = 32'h00000000;
          st_next.falls = 2'h0;
          if ((st_reg.xsum ^ word_val) == st_reg.chk) begin
            st_next.phase = PH_DONEWAIT;
          end else begin
            st_next.phase = PH_ERROR;
          end
        end
      end
      PH_ERROR: begin
        // auto restart only in the passive schemes
        if (st_reg.ctrl[`FCSC_CTRL_AUTO] && passive) begin
          if (st_reg.cnt == STATUS_REL_CYC - 32'h00000001) begin
            st_next.phase = PH_RESET;
          end else begin
            st_next.cnt = st_reg.cnt + 32'h00000001;
          end
        end
      end
      PH_DONEWAIT: begin
        // passive host hands over two falling clock edges
        if (!passive || st_reg.falls == 2'h2) begin
          st_next.phase = PH_CLKDLY;
        end else if (config_clock_fall) begin
          st_next.falls = st_reg.falls + 2'h1;
        end
      end
      PH_CLKDLY: begin
        // fixed delay before the init clock is enabled
        if (st_reg.cnt == CD2CU_CYC - 32'h00000001) begin
          st_next.phase = PH_INIT;
          st_next.cnt   = 32'h00000000;
        end else begin
          st_next.cnt = st_reg.cnt + 32'h00000001;
        end
      end
      PH_INIT: begin
        // init cycle count before user mode
        if (init_edge) begin
          if (st_reg.cnt == INIT_CYCLES - 32'h00000001) begin
            st_next.phase = PH_USER;
          end else begin
            st_next.cnt = st_reg.cnt + 32'h00000001;
          end
        end
      end
      PH_USER: begin
        st_next.init_done = st_reg.ctrl[`FCSC_CTRL_INITEN];
      end
    endcase

    // request pulse overrides every phase past power-on reset
    if (req_pulse && st_reg.phase != PH_POR) begin
      st_next.phase     = PH_RESET;
      st_next.init_done = 1'b0;
      st_next.cnt       = 32'h00000000;
    end
    st_next.cram.clear = (st_next.phase == PH_POR);

    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid && !st_reg.aw_full && !st_reg.bvalid) begin
      st_next.aw_full = 1'b1;
      st_next.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_full && !st_reg.bvalid) begin
      st_next.w_full = 1'b1;
      st_next.wdata  = s_axi_wdata;
      st_next.wstrb  = s_axi_wstrb;
    end
    if (st_reg.aw_full && st_reg.w_full) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = `FCSC_RESP_OKAY;
      unique case (st_reg.awaddr)
        `FCSC_ADDR_CTRL: begin
          merged       = fcsc_merge({26'h0000000, st_reg.ctrl}, st_reg.wdata, st_reg.wstrb);
          st_next.ctrl = merged[5:0];
        end
        `FCSC_ADDR_LEN: begin
          merged      = fcsc_merge({16'h0000, st_reg.len}, st_reg.wdata, st_reg.wstrb);
          st_next.len = merged[15:0];
        end
        `FCSC_ADDR_CHK: begin
          merged      = fcsc_merge({16'h0000, st_reg.chk}, st_reg.wdata, st_reg.wstrb);
          st_next.chk = merged[15:0];
        end
        `FCSC_ADDR_STATUS, `FCSC_ADDR_WORDS: st_next.bresp = `FCSC_RESP_OKAY;
        default: st_next.bresp = `FCSC_RESP_SLVERR;
      endcase
    end else if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // AXI4-Lite read: answer one cycle after the address is taken
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `FCSC_RESP_OKAY;
      unique case (s_axi_araddr)
        `FCSC_ADDR_CTRL:   rd = {26'h0000000, st_reg.ctrl};
        `FCSC_ADDR_STATUS: rd = {24'h000000, st_reg.init_done,
                                 st_reg.stat_s[1], st_reg.req_s[1], 2'h0, st_reg.phase};
        `FCSC_ADDR_LEN:    rd = {16'h0000, st_reg.len};
        `FCSC_ADDR_CHK:    rd = {16'h0000, st_reg.chk};
        `FCSC_ADDR_WORDS:  rd = {16'h0000, st_reg.words};
        default:           st_next.rresp = `FCSC_RESP_SLVERR;
      endcase
      st_next.rdata = rd;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // ***********************************************************************
  // state register
  // ***********************************************************************
  // clock enable freezes everything, bus slave included
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg       <= '0;
      st_reg.phase <= PH_POR;
      st_reg.ctrl  <= `FCSC_CTRL_RST;
      st_reg.len   <= `FCSC_LEN_RST;
      st_reg.cram  <= '{word: 16'h0000, we: 1'b0, clear: 1'b1};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  fcsc_od_t status_line;
  fcsc_od_t done_line;

  // status held low in power-on reset, request-held reset, error
  assign status_line.drive_low = (st_reg.phase == PH_POR) || (st_reg.phase == PH_ERROR) ||
                                 (st_reg.phase == PH_RESET && !st_reg.req_s[1]);
  assign status_line.level_in  = config_status_n_in;
  // done released only once loading succeeded
  assign done_line.drive_low   = (st_reg.phase <= PH_ERROR);
  assign done_line.level_in    = load_complete_line_in;

  assign config_status_n_out    = 1'b0;
  assign config_status_n_oe     = status_line.drive_low;
  assign load_complete_line_out = 1'b0;
  assign load_complete_line_oe  = done_line.drive_low;
  assign config_clock_out       = st_reg.as_clk;
  assign config_clock_oe        = (st_reg.phase == PH_CONFIG) &&
                                  (st_reg.ctrl[`FCSC_CTRL_SCHEME] == SCH_ACTIVE_SERIAL);
  assign cram                   = st_reg.cram;
  // pins float with pull-ups until user mode
  assign user_io_tristate       = (st_reg.phase != PH_USER);
  assign user_pullup_en         = (st_reg.phase != PH_USER);
  assign init_done              = st_reg.init_done;

  assign s_axi_awready = !st_reg.aw_full && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_full && !st_reg.bvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  // ***********************************************************************
  // checks
  // ***********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_cfg_entry;
    st_reg.phase == PH_RESET ##1 st_reg.phase == PH_CONFIG;
  endsequence
  sequence s_load_ok;
    st_reg.phase == PH_CONFIG ##1 st_reg.phase == PH_DONEWAIT;
  endsequence

  chk_por_status_low: assert property (
    st_reg.phase == PH_POR |-> config_status_n_oe && user_io_tristate && cram.clear)
    else $error("power-on reset lines wrong");
  chk_por_length: assert property (
    (st_reg.phase == PH_POR && st_reg.por_arm == 2'h3 && st_reg.cnt != 32'h00000000 && clk_en)
    |=> st_reg.phase == PH_POR)
    else $error("power-on reset left early");
  chk_reset_hold: assert property (
    (st_reg.phase == PH_RESET && !st_reg.req_s[1]) |-> config_status_n_oe ##1
    (st_reg.phase != PH_CONFIG))
    else $error("reset left with request low");
  chk_io_float: assert property (
    st_reg.phase != PH_USER |-> user_io_tristate && user_pullup_en)
    else $error("user pins active before user mode");
  chk_config_entry: assert property (
    s_cfg_entry |-> $past(st_reg.req_s[1]) && $past(st_reg.stat_s[1]))
    else $error("loading began without both lines high");
  chk_word_capture: assert property (
    cram.we |-> $past(st_reg.phase) == PH_CONFIG && $past(clk_en))
    else $error("word written outside loading");
  chk_done_release: assert property (
    s_load_ok |-> !load_complete_line_oe && st_reg.words == st_reg.len)
    else $error("done released with words missing");
  chk_error_lines: assert property (
    st_reg.phase == PH_ERROR |-> config_status_n_oe && load_complete_line_oe)
    else $error("error lines not held low");
  chk_init_done: assert property (
    $rose(init_done) |-> st_reg.phase == PH_USER && st_reg.ctrl[`FCSC_CTRL_INITEN])
    else $error("init done rose outside user mode");

endmodule : fcsc_loader

// file: fcsc_loader_tb_top.sv
/* bench for the config sequence controller over axi4-lite and its pins.
   assumes fcsc_host stands on the far side. */
`timescale 1ns/1ps
module fcsc_loader_tb_top;
  logic clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic config_request_n, config_clock_in, config_status_n_in, config_status_n_oe;
  logic load_complete_line_in, load_complete_line_oe, user_io_tristate, user_pullup_en;
  logic init_done, clk_en, user_init_clock, config_status_n_out, load_complete_line_out;
  logic config_clock_out, config_clock_oe;
  logic [3:0] s_axi_wstrb, serial_config_data;
  logic [2:0] mode_select_pins;
  fcsc_pkg::fcsc_cram_t cram;
  logic [15:0] config_data;
  int error_cnt, tests_run, n;
  // short counts keep the run brief
  fcsc_loader #(.POR_SHORT_CYC(32'h14), .POR_LONG_CYC(32'h28), .INIT_CYCLES(32'h8)) i_dut (
    .clk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .config_request_n,
    .config_status_n_in, .config_status_n_out, .config_status_n_oe, .load_complete_line_in,
    .load_complete_line_out, .load_complete_line_oe, .config_clock_in, .config_clock_out,
    .config_clock_oe, .config_data, .serial_config_data, .user_init_clock,
    .mode_select_pins, .cram, .user_io_tristate, .user_pullup_en, .init_done);
  fcsc_host i_host (.config_request_n, .config_clock_in, .config_data, .config_status_n_in,
    .load_complete_line_in, .config_status_n_oe, .load_complete_line_oe);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // user clock runs free, through restarts too
  initial begin
    user_init_clock = 1'b0;
    forever #24 user_init_clock = ~user_init_clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // handshakes are judged at the falling edge, so nothing races the rising one
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    forever begin
      @(negedge clk);
      ha = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bready & s_axi_bvalid | s_axi_rready & s_axi_rvalid;
      q = s_axi_rdata;
      rs = w ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      if (ha) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) begin
        {s_axi_bready, s_axi_rready} <= 2'h0;
        break;
      end
    end
  endtask : axi
  task automatic por_check();
    chk({config_status_n_oe, user_io_tristate, cram.clear, config_status_n_out}, 4'hE);
    for (n = 0; n < 300 && config_status_n_oe; n++) @(posedge clk);
    chk(n >= 20 && n < 40, 1); // short delay picked
    axi(0, 8'h00, 32'h0);
    chk(q, 32'h3);
    axi(0, 8'h20, 32'h0);
    chk(rs, 2'h2);
    chk(user_io_tristate, 1); // pins still float
    axi(0, 8'h04, 32'h0);
    chk(q[2:0], 3'h2); // loading begins
  endtask : por_check
  task automatic load_ok();
    axi(1, 8'h08, 32'h2);
    axi(1, 8'h0C, 32'hB9F9);
    chk(rs, 2'h0);
    #1 i_host.send(16'h1234); // first word
    chk(load_complete_line_oe, 1); // not early
    i_host.send(16'hABCD); // last word
    axi(0, 8'h10, 32'h0);
    chk(q, 32'h2); // both words taken
    chk(load_complete_line_oe, 0); // done released
    chk({cram.word, config_clock_oe, config_clock_out, load_complete_line_out}, {16'hABCD, 3'h0});
    #1 i_host.send(16'h0000); // trailing clock edges
    i_host.send(16'h0000);
    for (n = 0; n < 2000 && !init_done; n++) @(posedge clk);
    chk(init_done, 1); // init finished
    chk({user_io_tristate, user_pullup_en}, 2'h0); // pins handed over
    axi(0, 8'h04, 32'h0);
    chk(q[2:0], 3'h7); // user phase
  endtask : load_ok
  task automatic req_pulse();
    i_host.pulse(510); // long request pulse
    chk({config_status_n_oe, load_complete_line_oe, user_io_tristate, init_done}, 4'hE);
    for (n = 0; n < 100 && config_status_n_oe; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    axi(0, 8'h04, 32'h0);
    chk(q[2:0], 3'h2); // back to loading
  endtask : req_pulse
  task automatic err_restart();
    axi(1, 8'h08, 32'h1);
    axi(1, 8'h0C, 32'h0);
    #1 i_host.send(16'h00FF);
    chk({config_status_n_oe, load_complete_line_oe}, 2'h3); // bad checksum
    for (n = 0; n < 700 && config_status_n_oe; n++) @(posedge clk);
    chk(n >= 490 && n < 700, 1); // release delay
  endtask : err_restart
  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial begin
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {clk_en, s_axi_wstrb, serial_config_data, mode_select_pins} = {1'b1, 4'hF, 4'h5, 3'h0};
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    por_check();
    load_ok();
    req_pulse();
    err_restart();
    close_out();
  end
  // whole run needs about 1400 cycles
  initial begin
    #60000;
    error_cnt++;
    close_out();
  end
endmodule : fcsc_loader_tb_top

// file: fcsc_params.svh
/*
  Constants of the configuration sequence controller: register offsets,
  control field positions, reset values and timing figures.
  Assumes a 250 MHz system clock and inclusion by bare name.
*/
// How it works
// - Power-on reset holds status low, clears memory, floats user pins.
// - Mode-select pin level picks the power-on reset delay length.
// - Request low keeps reset; status released only with request high.
// - User pins stay floating until configuration has finished.
// - Loading starts only with request and status both high.
// - Passive schemes capture data on each rising host clock edge.
// - Active serial scheme makes its own clock, reads serial data pins.
// - All words received cleanly releases the done line high.
// - Passive clock may pause indefinitely held low; device tolerates it.
// - Configuration error drives status low and keeps done low.
// - Passive with auto restart releases status after delay and retries.
// - Init follows done high; passive host gives two falling edges.
// - Init clock selectable: internal oscillator default, user or config.
// - After done, clock enabled after fixed delay, then init cycles counted.
// - User init clock toggling has no effect on configuration itself.
// - Optional init-complete output rises on entering user mode.
// - User mode removes weak pull-ups, pins run as designed.
// - Long enough request low pulse restarts; status, done low, pins float.
`ifndef FCSC_PARAMS_SVH
`define FCSC_PARAMS_SVH

// ***********************************************************************
// register map
// ***********************************************************************
`define FCSC_ADDR_CTRL      8'h00
`define FCSC_ADDR_STATUS    8'h04
`define FCSC_ADDR_LEN       8'h08
`define FCSC_ADDR_CHK       8'h0C
`define FCSC_ADDR_WORDS     8'h10
`define FCSC_CTRL_AUTO      0
`define FCSC_CTRL_INITEN    1
`define FCSC_CTRL_CLKSEL    3:2
`define FCSC_CTRL_SCHEME    5:4
`define FCSC_CTRL_RST       6'h03
`define FCSC_LEN_RST        16'h0100
`define FCSC_RESP_OKAY      2'h0
`define FCSC_RESP_SLVERR    2'h2

// ***********************************************************************
// timing
// ***********************************************************************
`define FCSC_CLK_PERIOD_NS  4
`define FCSC_CLK_KHZ        250000
`define FCSC_OSC_KHZ        12500
`define FCSC_POR_SHORT_NS   4000000
`define FCSC_POR_LONG_NS    12000000
`define FCSC_STATUS_REL_NS  2000
`define FCSC_CFG_PULSE_NS   2000
`define FCSC_CD2CU_NS       300
`define FCSC_INIT_CYCLES    1024
`define FCSC_AS_HALF_CYC    4
`define FCSC_CYC_UP(ns)     (((ns) + `FCSC_CLK_PERIOD_NS - 1) / `FCSC_CLK_PERIOD_NS)
`define FCSC_OSC_HALF_CYC   (`FCSC_CLK_KHZ / `FCSC_OSC_KHZ / 2)

`endif

// file: fcsc_pkg.sv
/*
  Types of the configuration sequence controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcsc_pkg;

  // ***********************************************************************
  // enumerations
  // ***********************************************************************
  typedef enum logic [2:0] {
    PH_POR      = 3'b000,
    PH_RESET    = 3'b001,
    PH_CONFIG   = 3'b010,
    PH_ERROR    = 3'b011,
    PH_DONEWAIT = 3'b100,
    PH_CLKDLY   = 3'b101,
    PH_INIT     = 3'b110,
    PH_USER     = 3'b111
  } fcsc_phase_t;

  typedef enum logic [1:0] {
    SCH_PARALLEL_PASSIVE = 2'b00,
    SCH_SERIAL_PASSIVE   = 2'b01,
    SCH_ACTIVE_SERIAL    = 2'b10,
    SCH_SPARE            = 2'b11
  } fcsc_scheme_t;

  // ***********************************************************************
  // carriers
  // ***********************************************************************
  typedef struct packed {
    logic        drive_low;   // open-drain pulls low
    logic        level_in;
  } fcsc_od_t;

  typedef struct packed {
    logic [15:0] word;
    logic        we;
    logic        clear;
  } fcsc_cram_t;

endpackage : fcsc_pkg
